// ### shared/pzs_pkg.sv
// Purpose: shared constants for the pipelined zero-turnaround sram
// Assumes: one clock, widths given by the wide organisation
// Notes:   narrow variant is data 18, address 20, lanes 2

package pzs_pkg;

   // ----------------------------------------------------------------
   // array organisation
   // ----------------------------------------------------------------
   localparam int PZS_ADDR_W     = 19;  // 524288 words
   localparam int PZS_DATA_W     = 36;
   localparam int PZS_LANES      = 4;   // nine bits per lane
   localparam int PZS_NARROW_A_W = 20;  // 1048576 words
   localparam int PZS_NARROW_D_W = 18;

   // ----------------------------------------------------------------
   // burst counter and buffering
   // ----------------------------------------------------------------
   localparam int PZS_BEAT_W     = 2;
   localparam logic [1:0] PZS_BEAT_ONE = 2'h1;
   localparam int PZS_FIFO_DEPTH = 8;

   // burst order pin encoding
   typedef enum logic
   {
      PZS_BURST_LINEAR      = 1'b0,
      PZS_BURST_INTERLEAVED = 1'b1
   } pzs_burst_t;

endpackage

// ### logic/pzs_fifo.sv
// Purpose: small write-data buffer with valid/ready on both sides
// Assumes: DEPTH is a power of two
// Notes:   in_ready falls only when every slot is occupied

`timescale 1ns/10ps

module pzs_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
)(
   // clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // filling side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // draining side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);

   localparam int PW = $clog2(DEPTH);

   typedef struct packed
   {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [PW-1:0]               wr_ptr;
      logic [PW-1:0]               rd_ptr;
      logic [PW:0]                 count;
   } pzs_fifo_state_t;

   pzs_fifo_state_t st_reg;
   pzs_fifo_state_t st_next;
   logic            push;
   logic            pop;

   // honest flags straight from the occupancy count
   assign in_ready  = (st_reg.count != (PW+1)'(DEPTH));
   assign out_valid = (st_reg.count != '0);
   assign out_data  = st_reg.mem[st_reg.rd_ptr];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   // pointer and count update
   always_comb
   begin
      st_next = st_reg;
      if (push)
      begin
         st_next.mem[st_reg.wr_ptr] = in_data;
         st_next.wr_ptr = st_reg.wr_ptr + PW'(1);
      end
      if (pop)
      begin
         st_next.rd_ptr = st_reg.rd_ptr + PW'(1);
      end
      st_next.count = st_reg.count + (PW+1)'(push) - (PW+1)'(pop);
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

endmodule

// ### logic/pzs_store.sv
// Purpose: the storage array, byte-lane writable
// Assumes: one write port and one unclocked read port
// Notes:   contents are not reset, like a real memory

`timescale 1ns/10ps

module pzs_store #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 36,
   parameter int LANES  = 4
)(
   // clock
   input  wire logic              clk,
   // read port
   input  wire logic [ADDR_W-1:0] rd_addr,
   output logic      [DATA_W-1:0] rd_data,
   // write port
   input  wire logic              wr_en,
   input  wire logic [ADDR_W-1:0] wr_addr,
   input  wire logic [LANES-1:0]  wr_lanes,
   input  wire logic [DATA_W-1:0] wr_data
);

   localparam int LW = DATA_W / LANES;

   logic [DATA_W-1:0] mem [2**ADDR_W];

   assign rd_data = mem[rd_addr];

   // each enabled lane is written on its own
   always_ff @(posedge clk)
   begin
      for (int i = 0; i < LANES; i++)
      begin
         if (wr_en && wr_lanes[i])
            mem[wr_addr][i*LW +: LW] <= wr_data[i*LW +: LW];
      end
   end

endmodule

// ### logic/pzs_sram.sv
// Purpose: pipelined zero-turnaround synchronous sram core
// Assumes: command pins are synchronous to clk; mode, sleep and
//          output enable are asynchronous
// Notes:   write data is buffered before the array; reads forward it

`timescale 1ns/10ps

module pzs_sram #(
   parameter int ADDR_W     = pzs_pkg::PZS_ADDR_W,
   parameter int DATA_W     = pzs_pkg::PZS_DATA_W,
   parameter int LANES      = pzs_pkg::PZS_LANES,
   parameter int FIFO_DEPTH = pzs_pkg::PZS_FIFO_DEPTH
)(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rst_n,
   // synchronous command pins
   input  wire logic [ADDR_W-1:0] addr,
   input  wire logic              write_n,
   input  wire logic              advance_or_load,
   input  wire logic              chip_select_a_n,
   input  wire logic              chip_select_b,
   input  wire logic              chip_select_c_n,
   input  wire logic              clock_hold_n,
   input  wire logic              byte_lane0_write_n,
   input  wire logic              byte_lane1_write_n,
   input  wire logic              byte_lane2_write_n,
   input  wire logic              byte_lane3_write_n,
   // data bus, split into its three signals
   input  wire logic [DATA_W-1:0] data_in,
   output logic      [DATA_W-1:0] data_out,
   output logic                   data_oe,
   // asynchronous pins
   input  wire logic              out_enable_n,
   input  wire logic              burst_mode,
   input  wire logic              sleep_request,
   // status
   output logic                   power_down
);

   localparam int LW = DATA_W / LANES;
   localparam int FW = ADDR_W + LANES + DATA_W;

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed
   {
      logic              mode_s1;   // burst order synchroniser
      logic              mode_s2;
      logic              slp_s1;    // sleep synchroniser
      logic              slp_s2;
      logic              burst_on;
      logic              burst_wr;
      logic [ADDR_W-1:0] base;
      logic [1:0]        beat;
      logic              c1_vld;    // command stage
      logic              c1_wr;
      logic [ADDR_W-1:0] c1_addr;
      logic [LANES-1:0]  c1_lanes;
      logic              c2_vld;    // data stage
      logic              c2_wr;
      logic [ADDR_W-1:0] c2_addr;
      logic [LANES-1:0]  c2_lanes;
      logic [DATA_W-1:0] rd_data;
      logic              rd_oe;
      logic              pdown;
   } pzs_state_t;

   pzs_state_t        st_reg;
   pzs_state_t        st_next;
   logic [3:0]        lanes_all;
   logic [LANES-1:0]  lanes_now;
   logic              selected;
   logic              stall;
   logic              go;
   logic [DATA_W-1:0] mem_rd;
   logic [DATA_W-1:0] fwd_data;
   logic              f_in_valid;
   logic              f_in_ready;
   logic              f_out_valid;
   logic [FW-1:0]     f_out_data;
   logic [ADDR_W-1:0] f_addr;
   logic [LANES-1:0]  f_lanes;
   logic [DATA_W-1:0] f_data;

   // ----------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------
   // replaces the enabled lanes of old_d with those of new_d
   function automatic logic [DATA_W-1:0] merge_lanes(
      input logic [DATA_W-1:0] old_d,
      input logic [DATA_W-1:0] new_d,
      input logic [LANES-1:0]  en);
      logic [DATA_W-1:0] r;
      r = old_d;
      for (int i = 0; i < LANES; i++)
      begin
         if (en[i])
            r[i*LW +: LW] = new_d[i*LW +: LW];
      end
      return r;
   endfunction

   // beat address, add or xor beat
   function automatic logic [ADDR_W-1:0] burst_addr(
      input logic [ADDR_W-1:0] base,
      input logic [1:0]        beat,
      input logic              mode);
      logic [1:0] low;
      low = base[1:0] + beat;
      if (mode == pzs_pkg::PZS_BURST_INTERLEAVED)
         low = base[1:0] ^ beat;
      return {base[ADDR_W-1:2], low};
   endfunction

   // ----------------------------------------------------------------
   // pin decode
   // ----------------------------------------------------------------
   // selects are active low on a and c; upper lanes unused when narrow
   // lanes active low
   assign lanes_all = ~{byte_lane3_write_n, byte_lane2_write_n,
                        byte_lane1_write_n, byte_lane0_write_n};
   assign lanes_now = lanes_all[LANES-1:0];
   // sleep blocks new work the same way a deselect does
   assign selected  = ~chip_select_a_n & chip_select_b &
                      ~chip_select_c_n & ~st_reg.slp_s2;
   // a full buffer stalls the pipeline registers like a clock hold; the buffer itself keeps draining
   // hold or full buffer
   assign stall     = clock_hold_n | (st_reg.c2_vld & st_reg.c2_wr &
                      ~f_in_ready);
   assign go        = ~stall;

   // ----------------------------------------------------------------
   // write buffer and array
   // ----------------------------------------------------------------
   // write data enters the buffer in the cycle it is on the bus
   assign f_in_valid = ~clock_hold_n & st_reg.c2_vld & st_reg.c2_wr;
   assign {f_addr, f_lanes, f_data} = f_out_data;

   pzs_fifo #(
      .WIDTH (FW),
      .DEPTH (FIFO_DEPTH)
   ) u_wbuf (
      .clk       (clk),
      .rst_n     (rst_n),
      .in_valid  (f_in_valid),
      .in_ready  (f_in_ready),
      .in_data   ({st_reg.c2_addr, st_reg.c2_lanes, data_in}),
      .out_valid (f_out_valid),
      .out_ready (~clock_hold_n),
      .out_data  (f_out_data)
   );

   pzs_store #(
      .ADDR_W (ADDR_W),
      .DATA_W (DATA_W),
      .LANES  (LANES)
   ) u_store (
      .clk      (clk),
      .rd_addr  (st_reg.c1_addr),
      .rd_data  (mem_rd),
      .wr_en    (f_out_valid & ~clock_hold_n),
      .wr_addr  (f_addr),
      .wr_lanes (f_lanes),
      .wr_data  (f_data)
   );

   // read data sees writes not yet in the array; youngest wins
   // forwarding, no dead cycle
   always_comb
   begin
      fwd_data = mem_rd;
      if (f_out_valid && f_addr == st_reg.c1_addr)
         fwd_data = merge_lanes(fwd_data, f_data, f_lanes);
      if (st_reg.c2_vld && st_reg.c2_wr &&
          st_reg.c2_addr == st_reg.c1_addr)
         fwd_data = merge_lanes(fwd_data, data_in, st_reg.c2_lanes);
   end

   // ----------------------------------------------------------------
   // pipeline
   // ----------------------------------------------------------------
   always_comb
   begin
      st_next = st_reg;
      if (go)
      begin
         // mode and sleep are asynchronous, two flops each
         st_next.mode_s1 = burst_mode;
         st_next.mode_s2 = st_reg.mode_s1;
         st_next.slp_s1  = sleep_request;
         st_next.slp_s2  = st_reg.slp_s1;
         st_next.c1_vld   = 1'b0;
         st_next.c1_wr    = 1'b0;
         st_next.c1_lanes = lanes_now;
         if (!advance_or_load)
         begin
            if (selected)
            begin
               st_next.base     = addr;
               st_next.beat     = '0;
               st_next.burst_on = 1'b1;
               st_next.burst_wr = ~write_n;
               st_next.c1_vld   = 1'b1;
               st_next.c1_wr    = ~write_n;
               st_next.c1_addr  = addr;
            end
            else
            begin
               st_next.burst_on = 1'b0;
            end
         end
         else if (st_reg.burst_on)
         begin
            st_next.beat    = st_reg.beat + pzs_pkg::PZS_BEAT_ONE;
            st_next.c1_vld  = 1'b1;
            st_next.c1_wr   = st_reg.burst_wr;
            st_next.c1_addr = burst_addr(st_reg.base, st_next.beat,
                                         st_reg.mode_s2);
         end
         st_next.c2_vld   = st_reg.c1_vld;
         st_next.c2_wr    = st_reg.c1_wr;
         st_next.c2_addr  = st_reg.c1_addr;
         st_next.c2_lanes = st_reg.c1_lanes;
         st_next.rd_oe = st_reg.c1_vld & ~st_reg.c1_wr;
         if (st_reg.c1_vld && !st_reg.c1_wr)
            st_next.rd_data = fwd_data;
         st_next.pdown = st_reg.slp_s2 |
                         (~st_next.c1_vld & ~st_reg.c1_vld &
                          ~st_reg.c2_vld & ~st_next.burst_on);
      end
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         st_reg <= '0;
      else
         st_reg <= st_next;
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   assign data_out   = st_reg.rd_data;
   assign data_oe    = st_reg.rd_oe & ~out_enable_n;
   assign power_down = st_reg.pdown;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);

   sequence s_load;
      go && !advance_or_load && selected;
   endsequence

   sequence s_rd_start;
      s_load and write_n;
   endsequence

   sequence s_wr_start;
      s_load and !write_n;
   endsequence

   chk_cmd_captured: assert property (
      s_load |=> st_reg.c1_vld && st_reg.c1_wr == !$past(write_n))
      else $error("command not captured");

   chk_read_latency: assert property (
      s_rd_start ##1 go |=> st_reg.rd_oe)
      else $error("read data not driven two cycles later");

   chk_write_float: assert property (
      s_wr_start ##1 go |=> !st_reg.rd_oe)
      else $error("bus driven during write data cycle");

   chk_desel_float: assert property (
      (go && !advance_or_load && !selected) ##1 go |=> !st_reg.rd_oe)
      else $error("bus driven after deselect");

   chk_pending_done: assert property (
      go && st_reg.c1_vld && !st_reg.c1_wr && !selected
      |=> st_reg.rd_oe)
      else $error("pending read lost on deselect");

   chk_hold_freeze: assert property (
      clock_hold_n |=> $stable(st_reg))
      else $error("state moved during clock hold");

   chk_burst_stop: assert property (
      go && !advance_or_load && !selected
      |=> !st_reg.burst_on && !st_reg.c1_vld)
      else $error("burst continues after deselect");

   chk_burst_step: assert property (
      go && advance_or_load && st_reg.burst_on
      |=> st_reg.c1_vld &&
          st_reg.beat == $past(st_reg.beat) + pzs_pkg::PZS_BEAT_ONE)
      else $error("burst counter did not advance");

   chk_burst_order: assert property (
      st_reg.c1_vld && st_reg.burst_on && $stable(st_reg.mode_s2)
      |-> st_reg.c1_addr[1:0] ==
          ((st_reg.mode_s2 == pzs_pkg::PZS_BURST_INTERLEAVED) ?
           (st_reg.base[1:0] ^ st_reg.beat) :
           (st_reg.base[1:0] + st_reg.beat)))
      else $error("burst address out of order");

   chk_oe_async: assert property (
      out_enable_n |-> !data_oe)
      else $error("outputs driven with output enable high");

   chk_sleep_down: assert property (
      go && !advance_or_load && st_reg.slp_s2 |=> power_down && !st_reg.c1_vld)
      else $error("no power down in sleep");

endmodule

// ### test/pzs_ctrl_model.sv
// Purpose: controller model issuing commands and write data to the sram
// Assumes: driven cycle by cycle through the cyc task from the bench
// Notes:   data_in toggles every cycle when no write data is due

`timescale 1ns/10ps

module pzs_ctrl_model #(
   parameter int ADDR_W = 19,
   parameter int DATA_W = 36
)(
   // clock
   input  wire logic              clk,
   // command pins
   output logic      [ADDR_W-1:0] addr,
   output logic                   write_n,
   output logic                   advance_or_load,
   output logic                   chip_select_a_n,
   output logic                   chip_select_b,
   output logic                   chip_select_c_n,
   output logic                   clock_hold_n,
   output logic      [3:0]        lanes_n,
   // write data
   output logic      [DATA_W-1:0] data_in
);
   logic              open_reg = 1'b0;
   logic              wr_reg   = 1'b0;
   logic              due1_reg = 1'b0;
   logic              due2_reg = 1'b0;
   logic [DATA_W-1:0] wd1_reg  = '0;
   logic [DATA_W-1:0] wd2_reg  = '0;
   logic [DATA_W-1:0] wd_new   = '0;
   logic              cs_ok;

   assign cs_ok = !chip_select_a_n && chip_select_b && !chip_select_c_n;

   initial
   begin
      {addr, write_n, chip_select_a_n, chip_select_b} = '0;
      {chip_select_c_n, clock_hold_n, lanes_n} = '0;
      advance_or_load = 1'b0;
   end

   // one command cycle, changed just after the falling edge
   task automatic cyc(input bit adv, input bit [2:0] cs, input bit wn,
                      input bit hold, input logic [ADDR_W-1:0] a,
                      input bit [3:0] ln);
      @(negedge clk);
      addr            <= a;
      advance_or_load <= adv;
      {chip_select_a_n, chip_select_b, chip_select_c_n} <= cs;
      write_n         <= wn;
      clock_hold_n    <= hold;
      lanes_n         <= ln;
      wd_new          <= DATA_W'({$urandom(), $urandom()});
   endtask

   // write data two taken cycles on, held through a stall
   always @(posedge clk)
   begin
      if (!clock_hold_n)
      begin
         if (!advance_or_load)
         begin
            open_reg <= cs_ok;
            wr_reg   <= !write_n;
         end
         due1_reg <= advance_or_load ? (open_reg && wr_reg)
                                     : (cs_ok && !write_n);
         due2_reg <= due1_reg;
         wd1_reg  <= wd_new;
         wd2_reg  <= wd1_reg;
      end
   end

   // data moves off the sampling edge; no stale value lingers
   always @(negedge clk)
      data_in <= due2_reg ? wd2_reg : ~data_in;
endmodule

// ### test/pzs_sram_tb_top.sv
// Purpose: self-checking bench for the pipelined sram core
// Assumes: addresses 0..15 are filled before any read
// Notes:   a cycle model shadows the pipeline and checks every edge

`timescale 1ns/10ps

`define CHK(g, e) \
   begin \
      num_checks++; \
      if ((g) !== (e)) \
      begin \
         errors++; \
         $display("[ERR] t=%0t got=%h exp=%h", $time, g, e); \
      end \
   end

module pzs_sram_tb_top;
   typedef struct packed {
      logic       v;
      logic       w;
      logic [3:0] a;
      logic [3:0] ln;
   } pzs_tbop_t;

   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [18:0] addr;
   logic        write_n, advance_or_load, clock_hold_n;
   logic        chip_select_a_n, chip_select_b, chip_select_c_n;
   logic [3:0]  lanes_n;
   logic [35:0] data_in, data_out;
   logic        data_oe, power_down;
   logic        out_enable_n = 1'b0;
   logic        burst_mode = 1'b0;
   logic        sleep_request = 1'b0;
   int          errors = 0;
   int          num_checks = 0;
   int          cycles = 0;
   logic [35:0] mem_m [16];
   pzs_tbop_t   p1, p2, nx;
   logic        open, bwr, s1, s2;
   logic [18:0] base;
   logic [1:0]  beat, lo;

   initial
   begin
      forever #2 clk = ~clk;
   end

   pzs_ctrl_model i_pzs_ctrl_model (
      .clk(clk), .addr(addr), .write_n(write_n),
      .advance_or_load(advance_or_load),
      .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
      .chip_select_c_n(chip_select_c_n), .clock_hold_n(clock_hold_n),
      .lanes_n(lanes_n), .data_in(data_in));

   pzs_sram i_pzs_sram (
      .clk(clk), .rst_n(rst_n), .addr(addr), .write_n(write_n),
      .advance_or_load(advance_or_load),
      .chip_select_a_n(chip_select_a_n), .chip_select_b(chip_select_b),
      .chip_select_c_n(chip_select_c_n), .clock_hold_n(clock_hold_n),
      .byte_lane0_write_n(lanes_n[0]), .byte_lane1_write_n(lanes_n[1]),
      .byte_lane2_write_n(lanes_n[2]), .byte_lane3_write_n(lanes_n[3]),
      .data_in(data_in), .data_out(data_out), .data_oe(data_oe),
      .out_enable_n(out_enable_n), .burst_mode(burst_mode),
      .sleep_request(sleep_request), .power_down(power_down));

   function automatic logic [35:0] merge_lanes(logic [35:0] o,
                                                logic [35:0] n,
                                                logic [3:0] en);
      for (int i = 0; i < 4; i++)
         if (en[i])
            o[i*9 +: 9] = n[i*9 +: 9];
      return o;
   endfunction

   // cycle model: checks the data cycle, then takes this edge's command
   always @(posedge clk)
   begin
      if (!rst_n)
      begin
         {p1, p2, open, bwr, s1, s2, beat} = '0;
      end
      else
      begin
         `CHK(data_oe, p2.v && !p2.w && !out_enable_n)
         if (p2.v && !p2.w)
            `CHK(data_out, mem_m[p2.a])
         // a held edge leaves every stage alone
         if (!clock_hold_n)
         begin
            // pending write lands, masked per lane
            if (p2.v && p2.w)
               mem_m[p2.a] = merge_lanes(mem_m[p2.a], data_in, p2.ln);
            // load or advance, sleep acting as deselect
            if (!advance_or_load)
            begin
               open = !chip_select_a_n && chip_select_b &&
                      !chip_select_c_n && !s2;
               base = addr;
               bwr  = !write_n;
               beat = 2'h0;
            end
            else
               beat = beat + 2'h1;
            // burst address from base and beat
            lo = burst_mode ? (base[1:0] ^ beat) : (base[1:0] + beat);
            nx = {open, bwr, base[3:2], lo, ~lanes_n};
            p2 = p1;
            p1 = nx;
            s2 = s1;
            s1 = sleep_request;
         end
      end
   end

   task automatic idle(input int n);
      repeat (n) i_pzs_ctrl_model.cyc(0, 3'b000, 1, 0, '0, 4'hf);
   endtask

   // random mix of loads, advances, deselects and stalls
   task automatic rnd_op();
      int       k;
      bit [2:0] cs;
      k  = $urandom_range(0, 7);
      cs = (k == 6) ? 3'($urandom_range(0, 7)) : 3'b010;
      if (k == 6 && cs == 3'b010)
         cs = 3'b110;
      i_pzs_ctrl_model.cyc(k >= 4 && k != 6, cs, !(k == 2 || k == 3),
                           k == 7, 19'($urandom_range(0, 15)),
                           4'($urandom()));
      out_enable_n <= ($urandom_range(0, 7) == 0);
   endtask

   task automatic close_out();
      $display("checks=%0d errors=%0d", num_checks, errors);
      if (errors == 0 && num_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask

   // hang guard, generous over the few hundred cycles of stimulus
   always @(posedge clk)
   begin
      cycles++;
      if (cycles == 1500)
      begin
         errors++;
         close_out();
      end
   end

   initial
   begin
      void'($urandom(32'h0199));
      repeat (10) @(posedge clk);
      @(negedge clk);
      rst_n <= 1'b1;
      // fill the window back to back with all lanes on
      for (int i = 0; i < 16; i++)
         i_pzs_ctrl_model.cyc(0, 3'b010, 0, 0, 19'(i), 4'h0);
      for (int m = 0; m < 2; m++)
      begin
         idle(1);
         burst_mode <= m[0];
         idle(4);
         repeat (80) rnd_op();
      end
      @(negedge clk);
      out_enable_n <= 1'b0;
      idle(6);
      `CHK(power_down, 1'b1)
      i_pzs_ctrl_model.cyc(0, 3'b010, 1, 0, 19'h5, 4'h0);
      i_pzs_ctrl_model.cyc(1, 3'b010, 1, 0, '0, 4'h0);
      i_pzs_ctrl_model.cyc(1, 3'b010, 1, 0, '0, 4'h0);
      `CHK(power_down, 1'b0)
      idle(4);
      // sleep raised only here, otherwise held low
      sleep_request <= 1'b1;
      idle(5);
      `CHK(power_down, 1'b1)
      i_pzs_ctrl_model.cyc(0, 3'b010, 1, 0, 19'h3, 4'h0);
      idle(3);
      sleep_request <= 1'b0;
      idle(4);
      close_out();
   end
endmodule
